// file: rtl/adp_pkg.sv
package adp_pkg;

	localparam int DW = 32;
	localparam int AW = 8;
	localparam int NLINES = 4;
	localparam int NPPB = 2;
	localparam int RES_W_DEF = 16;

	localparam logic [AW-1:0] OFS_INTCTL = 8'h00;
	localparam logic [AW-1:0] OFS_FLAG = 8'h04;
	localparam logic [AW-1:0] OFS_FLAGCLR = 8'h08;
	localparam logic [AW-1:0] OFS_OVF = 8'h0C;
	localparam logic [AW-1:0] OFS_OVFCLR = 8'h10;
	localparam logic [AW-1:0] OFS_IRQ_STS = 8'h14;
	localparam logic [AW-1:0] OFS_IRQ_MSK = 8'h18;

	// Each post-processing block owns five words starting here
	localparam int PPB_BASE = 'h20;
	localparam int PPB_STRIDE = 'h20;
	localparam logic [AW-1:0] PPB_OFFSET = 8'h00;
	localparam logic [AW-1:0] PPB_HI_LIM = 8'h04;
	localparam logic [AW-1:0] PPB_LO_LIM = 8'h08;
	localparam logic [AW-1:0] PPB_CTL = 8'h0C;
	localparam logic [AW-1:0] PPB_RESULT = 8'h10;

	localparam int CTL_HI_BIT = 0;
	localparam int CTL_LO_BIT = 1;
	localparam int CTL_ZC_BIT = 2;
	localparam int CTL_W = 3;

	localparam int EV_HI = 0;
	localparam int EV_LO = 1;
	localparam int EV_ZC = 2;
	localparam int EV_PER_PPB = 3;
	localparam int NEV = NPPB * EV_PER_PPB;

endpackage

// file: rtl/adp_ppb.sv
`timescale 1ns/100ps
module adp_ppb #(
	parameter int RES_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic [RES_W-1:0] result_i,
	input wire logic [RES_W-1:0] offset_i,
	input wire logic [RES_W-1:0] hi_lim_i,
	input wire logic [RES_W-1:0] lo_lim_i,
	input wire logic hi_en_i,
	input wire logic lo_en_i,
	input wire logic zc_en_i,
	output logic [RES_W:0] result_o,
	output logic hi_o,
	output logic lo_o,
	output logic zc_o
);
	logic [RES_W:0] diff;
	logic [RES_W:0] res_r, res_nxt;
	logic hi_r, hi_nxt, lo_r, lo_nxt, zc_r, zc_nxt;
	logic sign_r, sign_nxt, seen_r, seen_nxt;

	always_comb begin
		diff = {1'b0, result_i} - {1'b0, offset_i};
		res_nxt = res_r;
		sign_nxt = sign_r;
		seen_nxt = seen_r;
		hi_nxt = 1'b0;
		lo_nxt = 1'b0;
		zc_nxt = 1'b0;
		if (valid_i) begin
			res_nxt = diff;
			// Limits are judged on the raw bit pattern, so a negative result looks huge
			hi_nxt = hi_en_i && (diff > {1'b0, hi_lim_i});
			lo_nxt = lo_en_i && (diff < {1'b0, lo_lim_i});
			zc_nxt = zc_en_i && seen_r && (diff[RES_W] != sign_r);
			sign_nxt = diff[RES_W];
			seen_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_r <= '0;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
			zc_r <= 1'b0;
			sign_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			res_r <= res_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			zc_r <= zc_nxt;
			sign_r <= sign_nxt;
			seen_r <= seen_nxt;
		end
	end

	assign result_o = res_r;
	assign hi_o = hi_r;
	assign lo_o = lo_r;
	assign zc_o = zc_r;

	property p_sub;
		@(posedge clk_i) disable iff (rst_i)
		valid_i |=> result_o == ($past({1'b0, result_i}) - $past({1'b0, offset_i}));
	endproperty
	a_sub: assert property (p_sub) else $error("offset not subtracted");

	property p_hi_signed;
		@(posedge clk_i) disable iff (rst_i)
		valid_i && hi_en_i && (offset_i > result_i) |=> hi_o;
	endproperty
	a_hi_signed: assert property (p_hi_signed) else $error("signed result missed high trip");

	property p_lo_signed;
		@(posedge clk_i) disable iff (rst_i)
		valid_i && lo_en_i && (offset_i > result_i) |=> !lo_o;
	endproperty
	a_lo_signed: assert property (p_lo_signed) else $error("signed result gave low trip");

	sequence s_went_neg;
		valid_i && zc_en_i && seen_r && !sign_r && (offset_i > result_i);
	endsequence
	sequence s_zc_pulse;
		zc_o ##1 !zc_o;
	endsequence
	property p_zc;
		@(posedge clk_i) disable iff (rst_i)
		s_went_neg ##1 !valid_i |-> s_zc_pulse;
	endproperty
	a_zc: assert property (p_zc) else $error("zero crossing not flagged");
endmodule

// file: rtl/adp_top.sv
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - Each post-processing block subtracts its offset from the result, giving a signed value.
// - Limit compares treat the difference as unsigned, so signed results compare wrongly.
// - Continue bit zero: a set flag blocks further interrupts on its line.
// - Event meeting a flag-clear write leaves the flag set.
// - Event arriving while flag set raises the overflow flag for that line.
module adp_top #(
	parameter int RES_W = adp_pkg::RES_W_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [adp_pkg::AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [adp_pkg::DW-1:0] wb_dat_i,
	output logic [adp_pkg::DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic conv_valid_i,
	input wire logic [RES_W-1:0] conv_result_i,
	input wire logic [adp_pkg::NLINES-1:0] int_evt_i,
	output logic [adp_pkg::NLINES-1:0] adc_int_o,
	output logic irq_o
);
	import adp_pkg::*;

	logic ack_r, ack_nxt;
	logic [DW-1:0] dat_r, dat_nxt, rdata, wmask, wd;
	logic wr;
	logic [NLINES-1:0] cont_r, cont_nxt, flag_r, flag_nxt, ovf_r, ovf_nxt, int_r, int_nxt;
	logic [NLINES-1:0] clr, ovfclr;
	logic [NEV-1:0] sts_r, sts_nxt, msk_r, msk_nxt, ev;
	logic [RES_W-1:0] off_r [NPPB], off_nxt [NPPB];
	logic [RES_W-1:0] hil_r [NPPB], hil_nxt [NPPB];
	logic [RES_W-1:0] lol_r [NPPB], lol_nxt [NPPB];
	logic [CTL_W-1:0] ctl_r [NPPB], ctl_nxt [NPPB];
	logic [RES_W:0] pres [NPPB];

	// Both blocks see the same conversion so one can do limits, the other offset
	for (genvar g = 0; g < NPPB; g++) begin : g_ppb
		adp_ppb #(.RES_W(RES_W)) u_ppb (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.valid_i(conv_valid_i),
			.result_i(conv_result_i),
			.offset_i(off_r[g]),
			.hi_lim_i(hil_r[g]),
			.lo_lim_i(lol_r[g]),
			.hi_en_i(ctl_r[g][CTL_HI_BIT]),
			.lo_en_i(ctl_r[g][CTL_LO_BIT]),
			.zc_en_i(ctl_r[g][CTL_ZC_BIT]),
			.result_o(pres[g]),
			.hi_o(ev[g*EV_PER_PPB+EV_HI]),
			.lo_o(ev[g*EV_PER_PPB+EV_LO]),
			.zc_o(ev[g*EV_PER_PPB+EV_ZC])
		);
	end

	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wd = wb_dat_i & wmask;
	// Writes land on the edge where ack is seen, matching when the master lets go
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

	always_comb begin
		rdata = '0;
		case (wb_adr_i)
			OFS_INTCTL: rdata[NLINES-1:0] = cont_r;
			OFS_FLAG: rdata[NLINES-1:0] = flag_r;
			OFS_OVF: rdata[NLINES-1:0] = ovf_r;
			OFS_IRQ_STS: rdata[NEV-1:0] = sts_r;
			OFS_IRQ_MSK: rdata[NEV-1:0] = msk_r;
			OFS_FLAGCLR: rdata = '0;
			default: begin
				for (int p = 0; p < NPPB; p++) begin
					if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_OFFSET)
						rdata[RES_W-1:0] = off_r[p];
					if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_HI_LIM)
						rdata[RES_W-1:0] = hil_r[p];
					if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_LO_LIM)
						rdata[RES_W-1:0] = lol_r[p];
					if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_CTL)
						rdata[CTL_W-1:0] = ctl_r[p];
					if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_RESULT)
						rdata = {{(DW-RES_W-1){pres[p][RES_W]}}, pres[p]};
				end
			end
		endcase
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		dat_nxt = ack_nxt ? rdata : '0;
	end

	always_comb begin
		cont_nxt = cont_r;
		msk_nxt = msk_r;
		clr = '0;
		ovfclr = '0;
		for (int p = 0; p < NPPB; p++) begin
			off_nxt[p] = off_r[p];
			hil_nxt[p] = hil_r[p];
			lol_nxt[p] = lol_r[p];
			ctl_nxt[p] = ctl_r[p];
		end
		if (wr) begin
			if (wb_adr_i == OFS_INTCTL)
				cont_nxt = (cont_r & ~wmask[NLINES-1:0]) | wd[NLINES-1:0];
			if (wb_adr_i == OFS_IRQ_MSK)
				msk_nxt = (msk_r & ~wmask[NEV-1:0]) | wd[NEV-1:0];
			if (wb_adr_i == OFS_FLAGCLR)
				clr = wd[NLINES-1:0];
			if (wb_adr_i == OFS_OVFCLR)
				ovfclr = wd[NLINES-1:0];
			for (int p = 0; p < NPPB; p++) begin
				if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_OFFSET)
					off_nxt[p] = (off_r[p] & ~wmask[RES_W-1:0]) | wd[RES_W-1:0];
				if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_HI_LIM)
					hil_nxt[p] = (hil_r[p] & ~wmask[RES_W-1:0]) | wd[RES_W-1:0];
				if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_LO_LIM)
					lol_nxt[p] = (lol_r[p] & ~wmask[RES_W-1:0]) | wd[RES_W-1:0];
				if (wb_adr_i == AW'(PPB_BASE + p * PPB_STRIDE) + PPB_CTL)
					ctl_nxt[p] = (ctl_r[p] & ~wmask[CTL_W-1:0]) | wd[CTL_W-1:0];
			end
		end
		// A pending flag swallows new events unless the line runs in continue mode
		int_nxt = int_evt_i & (cont_r | ~flag_r);
		// Set beats clear, so an event racing a clear write keeps the flag up
		flag_nxt = (flag_r & ~clr) | int_evt_i;
		ovf_nxt = (ovf_r & ~ovfclr) | (int_evt_i & flag_r);
		sts_nxt = (sts_r & ~((wr && wb_adr_i == OFS_IRQ_STS) ? wd[NEV-1:0] : '0)) | ev;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
			cont_r <= '0;
			flag_r <= '0;
			ovf_r <= '0;
			int_r <= '0;
			sts_r <= '0;
			msk_r <= '0;
			for (int p = 0; p < NPPB; p++) begin
				off_r[p] <= '0;
				hil_r[p] <= '0;
				lol_r[p] <= '0;
				ctl_r[p] <= '0;
			end
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			cont_r <= cont_nxt;
			flag_r <= flag_nxt;
			ovf_r <= ovf_nxt;
			int_r <= int_nxt;
			sts_r <= sts_nxt;
			msk_r <= msk_nxt;
			for (int p = 0; p < NPPB; p++) begin
				off_r[p] <= off_nxt[p];
				hil_r[p] <= hil_nxt[p];
				lol_r[p] <= lol_nxt[p];
				ctl_r[p] <= ctl_nxt[p];
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign adc_int_o = int_r;
	assign irq_o = |(sts_r & msk_r);

	property p_block;
		@(posedge clk_i) disable iff (rst_i)
		(flag_r & ~cont_r) != '0 |=> (adc_int_o & $past(flag_r & ~cont_r)) == '0;
	endproperty
	a_block: assert property (p_block) else $error("interrupt passed a pending flag");

	property p_cont;
		@(posedge clk_i) disable iff (rst_i)
		(int_evt_i & cont_r) != '0 |=> (adc_int_o & $past(int_evt_i & cont_r)) == $past(int_evt_i & cont_r);
	endproperty
	a_cont: assert property (p_cont) else $error("continue mode lost an interrupt");

	property p_race;
		@(posedge clk_i) disable iff (rst_i)
		(int_evt_i & clr) != '0 |=> (flag_r & $past(int_evt_i & clr)) == $past(int_evt_i & clr);
	endproperty
	a_race: assert property (p_race) else $error("flag lost on clear race");

	property p_ovf;
		@(posedge clk_i) disable iff (rst_i)
		(int_evt_i & flag_r) != '0 |=> (ovf_r & $past(int_evt_i & flag_r)) == $past(int_evt_i & flag_r);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_clr;
		@(posedge clk_i) disable iff (rst_i)
		clr != '0 && int_evt_i == '0 |=> (flag_r & $past(clr)) == '0 && flag_r == $past(flag_r & ~clr);
	endproperty
	a_clr: assert property (p_clr) else $error("flag clear misbehaved");

	sequence s_rd_clr;
		wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && wb_adr_i == OFS_FLAGCLR;
	endsequence
	property p_clr_read;
		@(posedge clk_i) disable iff (rst_i)
		s_rd_clr |=> wb_ack_o && wb_dat_o == '0 ##1 !wb_ack_o;
	endproperty
	a_clr_read: assert property (p_clr_read) else $error("flag clear read not zero");
endmodule

// file: tb/adp_top_tb.sv
`timescale 1ns/100ps
module adp_top_tb;
import adp_pkg::*;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic wb_cyc_i = 1'b0;
logic wb_stb_i = 1'b0;
logic wb_we_i = 1'b0;
logic [AW-1:0] wb_adr_i = '0;
logic [3:0] wb_sel_i = 4'h0;
logic [DW-1:0] wb_dat_i = '0;
logic [DW-1:0] wb_dat_o;
logic wb_ack_o;
logic conv_valid_i = 1'b0;
logic [15:0] conv_result_i = 16'h0000;
logic [NLINES-1:0] int_evt_i = '0;
logic [NLINES-1:0] adc_int_o;
logic irq_o;
logic [3:0] evt_r = 4'h0;
logic sync_evt = 1'b0;
int err_total = 0;
int cmp_count = 0;
logic [31:0] q;
// Byte enables used by the next bus access; full word unless a scenario narrows it
logic [3:0] sel_v = 4'hF;

always #10 clk_i = ~clk_i;

// Lets a line-0 event land exactly on the edge where a bus write takes effect
always @(posedge clk_i)
	int_evt_i <= evt_r | ((sync_evt && wb_cyc_i && wb_stb_i && !wb_ack_o) ? 4'h1 : 4'h0);

adp_top #(.RES_W(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.conv_valid_i(conv_valid_i), .conv_result_i(conv_result_i), .int_evt_i(int_evt_i),
	.adc_int_o(adc_int_o), .irq_o(irq_o));

task automatic finish_test();
	if (err_total == 0 && cmp_count > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	cmp_count++;
	if (g !== e) begin
		err_total++;
		$display("BAD %s expected %h seen %h", nm, e, g);
	end
endtask

task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
	wb_cyc_i <= 1'b1;
	wb_stb_i <= 1'b1;
	wb_we_i <= we;
	wb_adr_i <= a;
	wb_dat_i <= d;
	wb_sel_i <= sel_v;
	do @(posedge clk_i); while (wb_ack_o !== 1'b1);
	q = wb_dat_o;
	wb_cyc_i <= 1'b0;
	wb_stb_i <= 1'b0;
	wb_we_i <= 1'b0;
	@(posedge clk_i);
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
	wb(1'b1, a, d);
endtask

task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
	wb(1'b0, a, 32'h0);
	chk(nm, e, q);
endtask

function automatic logic [7:0] pa(input int p, input logic [7:0] o);
	return 8'(PPB_BASE + PPB_STRIDE * p) + o;
endfunction

task automatic evt(input logic [3:0] v, input logic [3:0] e);
	evt_r <= v;
	@(posedge clk_i);
	evt_r <= 4'h0;
	@(posedge clk_i);
	#1 chk("adc_int", {28'h0, e}, {28'h0, adc_int_o});
	@(posedge clk_i);
endtask

task automatic conv(input logic [15:0] v);
	conv_valid_i <= 1'b1;
	conv_result_i <= v;
	@(posedge clk_i);
	conv_valid_i <= 1'b0;
	repeat (3) @(posedge clk_i);
endtask

task automatic t_reset();
	rd("intctl", OFS_INTCTL, 32'h0);
	rd("flag", OFS_FLAG, 32'h0);
	rd("ovf", OFS_OVF, 32'h0);
	rd("sts", OFS_IRQ_STS, 32'h0);
	rd("msk", OFS_IRQ_MSK, 32'h0);
	wr(8'hFC, 32'hFFFFFFFF);
	rd("unmapped", 8'hFC, 32'h0);
endtask

task automatic t_block();
	evt(4'h1, 4'h1);
	rd("flag", OFS_FLAG, 32'h1);
	evt(4'h1, 4'h0);
	rd("ovf", OFS_OVF, 32'h1);
	rd("flagclr", OFS_FLAGCLR, 32'h0);
	wr(OFS_FLAGCLR, 32'hE);
	rd("flag", OFS_FLAG, 32'h1);
	wr(OFS_FLAGCLR, 32'h1);
	rd("flag", OFS_FLAG, 32'h0);
	evt(4'h1, 4'h1);
	wr(OFS_FLAGCLR, 32'h1);
	wr(OFS_OVFCLR, 32'h1);
	rd("ovf", OFS_OVF, 32'h0);
endtask

task automatic t_coincide();
	sync_evt <= 1'b1;
	wr(OFS_FLAGCLR, 32'h1);
	sync_evt <= 1'b0;
	rd("flag", OFS_FLAG, 32'h1);
	evt(4'h1, 4'h0);
	wr(OFS_FLAGCLR, 32'h1);
	rd("ovf", OFS_OVF, 32'h1);
	wr(OFS_FLAGCLR, 32'h1);
	rd("flag", OFS_FLAG, 32'h0);
	wr(OFS_OVFCLR, 32'h1);
endtask

task automatic t_cont();
	wr(OFS_INTCTL, 32'hF);
	rd("intctl", OFS_INTCTL, 32'hF);
	evt(4'h3, 4'h3);
	evt(4'h3, 4'h3);
	rd("ovf", OFS_OVF, 32'h3);
	wr(OFS_FLAGCLR, 32'hF);
	wr(OFS_OVFCLR, 32'hF);
endtask

task automatic t_ppb();
	wr(pa(0, PPB_HI_LIM), 32'd100);
	wr(pa(0, PPB_LO_LIM), 32'd10);
	wr(pa(0, PPB_CTL), 32'h3);
	wr(pa(1, PPB_OFFSET), 32'd50);
	wr(pa(1, PPB_CTL), 32'h4);
	conv(16'd200);
	conv(16'd5);
	rd("sts", OFS_IRQ_STS, 32'h23);
	rd("res1", pa(1, PPB_RESULT), 32'hFFFFFFD3);
	rd("res0", pa(0, PPB_RESULT), 32'h5);
	chk("irq", 32'h0, {31'h0, irq_o});
	wr(OFS_IRQ_MSK, 32'h1);
	rd("msk", OFS_IRQ_MSK, 32'h1);
	chk("irq", 32'h1, {31'h0, irq_o});
	wr(OFS_IRQ_STS, 32'h3F);
	chk("irq", 32'h0, {31'h0, irq_o});
	// Offset with both compares on: negative result trips high, never low
	wr(pa(0, PPB_OFFSET), 32'd50);
	wr(pa(0, PPB_CTL), 32'h3);
	conv(16'd20);
	rd("sts", OFS_IRQ_STS, 32'h1);
	rd("res0", pa(0, PPB_RESULT), 32'hFFFFFFE2);
	chk("irq", 32'h1, {31'h0, irq_o});
	rd("hilim", pa(0, PPB_HI_LIM), 32'h64);
	// Only byte 1 enabled: the other bytes of the limit must keep their value
	sel_v = 4'h2;
	wr(pa(0, PPB_HI_LIM), 32'hFFFFABCD);
	sel_v = 4'hF;
	rd("hilim", pa(0, PPB_HI_LIM), 32'hAB64);
endtask

initial begin
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	t_reset();
	t_block();
	t_coincide();
	t_cont();
	t_ppb();
	finish_test();
end

initial begin
	repeat (3000) @(posedge clk_i);
	err_total++;
	finish_test();
end

endmodule
